// File: core/pci_master_burst_write64.sv
// Sequencer for a 64-bit PCI master burst write fed from a local master.
//
// Notes on behaviour
// - Devsel and source ready both low last cycle makes the core assert irdyn.
// - Taken strobes stay high (inactive) until the core takes the quadword.
// - Frame stays asserted while the burst runs and more than one phase remains.
// - A data phase completes on any clock with irdyn and trdyn both asserted.
// - The phase counter drops by one on the clock after each completed phase.
// - After target acceptance the next held quadword and enables go onto ad and cben.
// - Source ready asserted last cycle keeps irdyn asserted during the burst.
// - Source ready and trdyn both asserted last cycle asserts both taken strobes, except while the count is 2 or 1.
// - Final phase releases frame and req64 and deasserts both taken strobes.
// - After the width decision the core flags a 64-bit transfer to the local master.
// - After the last phase, float the bus, drop irdyn, zero the count, report normal end.
`timescale 1ns/1ns

module pci_master_burst_write64
   import burst_write_pkg::*;
#(
   parameter int DW = DATA_WIDTH,
   parameter int BW = BE_WIDTH,
   parameter int CW = COUNT_WIDTH
) (
   // Clock and reset.
   input  wire logic           clk,
   input  wire logic           reset,
   // Burst start from the address-phase logic.
   input  wire logic           start,
   input  wire logic [CW-1:0]  burstLength,
   // Local master write side.
   input  wire logic           localSourceReady_n,
   input  wire logic [DW-1:0]  localData,
   input  wire logic [BW-1:0]  localByteEnables,
   output logic                lowHalfTaken_n,
   output logic                highHalfTaken_n,
   output logic                wideTransferFlag_n,
   output logic [CW-1:0]       remainingPhaseCount,
   output logic [3:0]          masterStateCode,
   output logic [1:0]          endCause,
   // PCI pins, split into input, output and enable.
   input  wire logic           devsel_n,
   input  wire logic           trdy_n,
   output logic                frameOut_n,
   output logic                frameOe,
   output logic                req64Out_n,
   output logic                req64Oe,
   output logic                irdyOut_n,
   output logic                irdyOe,
   output logic [DW-1:0]       adOut,
   output logic [BW-1:0]       cbenOut,
   output logic                adOe
);

   // ****************************************
   // State record
   // ****************************************
   typedef struct packed {
      seq_state_t       state;
      logic             devselS1, devselS2, trdyS1, trdyS2;
      logic             readyPrev, devselPrev;
      logic             lowTaken, highTaken, wide;
      logic [CW-1:0]    count;
      logic [3:0]       code;
      logic [1:0]       cause;
      logic             frame, frameEn, req64, req64En, irdy, irdyEn;
      logic [DW-1:0]    held;
      logic [BW-1:0]    heldBe;
      logic [DW-1:0]    ad;
      logic [BW-1:0]    cbe;
      logic             adEn;
   } state_t;

   state_t  s_r;
   state_t  s_nxt;
   logic    phaseDone;
   logic    lastPhase;
   logic [DW-1:0] takenWord;
   logic [BW-1:0] takenBe;

   // The word under a taken strobe is read off the bus at the end of that cycle,
   // so it bypasses the holding register when it must go straight to the pins.
   assign takenWord = s_r.lowTaken ? s_r.held : localData;
   assign takenBe   = s_r.lowTaken ? s_r.heldBe : localByteEnables;

   // Data phase completes when both ready strobes are low on the same clock.
   assign phaseDone = !s_r.irdy && !s_r.trdyS2;
   assign lastPhase = (s_r.count == CW'(1));

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      // Two-flop synchronisers on the target's pins; only stage two is read.
      s_nxt.devselS1   = devsel_n;
      s_nxt.devselS2   = s_r.devselS1;
      s_nxt.trdyS1     = trdy_n;
      s_nxt.trdyS2     = s_r.trdyS1;
      s_nxt.readyPrev  = localSourceReady_n;
      s_nxt.devselPrev = s_r.devselS2;
      // Capture the quadword shown while the taken strobes are low.
      if (!s_r.lowTaken) begin
         s_nxt.held    = localData;
         s_nxt.heldBe  = localByteEnables;
      end
      // Strobes default to not taken.
      s_nxt.lowTaken   = 1'b1;
      s_nxt.highTaken  = 1'b1;
      case (s_r.state)
         ST_IDLE: begin
            s_nxt.cause = CAUSE_NONE;
            if (start) begin
               s_nxt.state   = ST_WAIT1;
               s_nxt.count   = burstLength;
               s_nxt.code    = CODE_DECIDE;
               s_nxt.frame   = 1'b0;
               s_nxt.frameEn = 1'b1;
               s_nxt.req64   = 1'b0;
               s_nxt.req64En = 1'b1;
               s_nxt.irdy    = 1'b1;
               s_nxt.irdyEn  = 1'b1;
               s_nxt.adEn    = 1'b1;
               // First quadword is taken with the address phase.
               if (!localSourceReady_n) begin
                  s_nxt.lowTaken  = 1'b0;
                  s_nxt.highTaken = 1'b0;
               end
            end
         end
         ST_WAIT1: begin
            // Taken quadword goes to the pins for the first data phase.
            s_nxt.ad    = takenWord;
            s_nxt.cbe   = takenBe;
            s_nxt.state = ST_WAIT2;
         end
         ST_WAIT2: begin
            s_nxt.wide = 1'b0;
            s_nxt.code = CODE_TRANSFER;
            if (!s_r.devselPrev && !s_r.readyPrev) begin
               s_nxt.irdy      = 1'b0;
               s_nxt.lowTaken  = 1'b0;
               s_nxt.highTaken = 1'b0;
               s_nxt.state     = ST_BURST;
            end
         end
         ST_BURST: begin
            if (phaseDone) begin
               // Target took the quadword on the pins; put up the next one.
               s_nxt.ad    = takenWord;
               s_nxt.cbe   = takenBe;
               s_nxt.count = s_r.count - CW'(1);
               if (s_r.count == CW'(2)) begin
                  // Next phase is the final one.
                  s_nxt.frame = 1'b1;
                  s_nxt.req64 = 1'b1;
               end else begin
                  s_nxt.frame = 1'b0;
               end
               if (lastPhase) begin
                  // Release the bus after the final phase.
                  s_nxt.frameEn = 1'b0;
                  s_nxt.req64En = 1'b0;
                  s_nxt.adEn    = 1'b0;
                  s_nxt.irdy    = 1'b1;
                  s_nxt.count   = COUNT_RESET;
                  s_nxt.code    = CODE_TERMINATE;
                  s_nxt.cause   = CAUSE_NORMAL;
                  s_nxt.state   = ST_END;
               end else if (!s_r.readyPrev && !s_r.trdyS2 && !(s_r.count == CW'(2))) begin
                  // A stalled phase takes nothing, so no quadword is skipped.
                  s_nxt.lowTaken  = 1'b0;
                  s_nxt.highTaken = 1'b0;
               end
            end
            if (!lastPhase || !phaseDone) begin
               if (!s_r.readyPrev) begin
                  s_nxt.irdy = 1'b0;
               end
            end
         end
         ST_END: begin
            // Turnaround cycle: hand irdyn back.
            s_nxt.irdyEn = 1'b0;
            s_nxt.wide   = 1'b1;
            s_nxt.code   = CODE_IDLE;
            s_nxt.state  = ST_IDLE;
         end
         default: begin
            s_nxt.state = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '{state: ST_IDLE, count: COUNT_RESET, code: CODE_IDLE, cause: CAUSE_NONE,
                  held: '0, heldBe: '0, ad: '0, cbe: '0, default: 1'b1};
         s_r.frameEn <= 1'b0;
         s_r.req64En <= 1'b0;
         s_r.irdyEn  <= 1'b0;
         s_r.adEn    <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state flops.
   assign lowHalfTaken_n      = s_r.lowTaken;
   assign highHalfTaken_n     = s_r.highTaken;
   assign wideTransferFlag_n  = s_r.wide;
   assign remainingPhaseCount = s_r.count;
   assign masterStateCode     = s_r.code;
   assign endCause            = s_r.cause;
   assign frameOut_n          = s_r.frame;
   assign frameOe             = s_r.frameEn;
   assign req64Out_n          = s_r.req64;
   assign req64Oe             = s_r.req64En;
   assign irdyOut_n           = s_r.irdy;
   assign irdyOe              = s_r.irdyEn;
   assign adOut               = s_r.ad;
   assign cbenOut             = s_r.cbe;
   assign adOe                = s_r.adEn;

endmodule : pci_master_burst_write64

// File: core/burst_write_pkg.sv
// Package of constants and types for the 64-bit master burst write sequencer.
package burst_write_pkg;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int             DATA_WIDTH      = 64;
   localparam int             BE_WIDTH        = 8;
   localparam int             COUNT_WIDTH     = 4;
   localparam logic [3:0]     COUNT_RESET     = 4'h0;

   // ****************************************
   // Master state codes shown to the local master
   // ****************************************
   localparam logic [3:0]     CODE_IDLE       = 4'h0;
   localparam logic [3:0]     CODE_DECIDE     = 4'h1;
   localparam logic [3:0]     CODE_TRANSFER   = 4'h2;
   localparam logic [3:0]     CODE_TERMINATE  = 4'h3;

   // ****************************************
   // End causes
   // ****************************************
   localparam logic [1:0]     CAUSE_NONE      = 2'h0;
   localparam logic [1:0]     CAUSE_NORMAL    = 2'h1;

   // ****************************************
   // Sequencer states, one-hot
   // ****************************************
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_WAIT1  = 5'h02,
      ST_WAIT2  = 5'h04,
      ST_BURST  = 5'h08,
      ST_END    = 5'h10
   } seq_state_t;

endpackage : burst_write_pkg

// File: verif/burst_write_chk.sv
// Checker for the burst write sequencer ports.
`timescale 1ns/1ns
module burst_write_chk
   import burst_write_pkg::*;
#(parameter int CW = COUNT_WIDTH) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Watched outputs.
   input wire logic lowHalfTaken_n,
   input wire logic highHalfTaken_n,
   input wire logic wideTransferFlag_n,
   input wire logic [CW-1:0] remainingPhaseCount,
   input wire logic [3:0] masterStateCode,
   input wire logic [1:0] endCause,
   input wire logic frameOut_n,
   input wire logic frameOe,
   input wire logic req64Out_n,
   input wire logic req64Oe,
   input wire logic irdyOut_n,
   input wire logic irdyOe,
   input wire logic adOe
);
   // ***
   // Properties
   // ***
   logic inXfer;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // High while the data phases run.
   assign inXfer = (masterStateCode == CODE_TRANSFER);
   sequence s_ended;
      !frameOe && !req64Oe && !adOe && irdyOut_n && remainingPhaseCount == '0 && endCause == CAUSE_NORMAL;
   endsequence
   sequence s_idle;
      !irdyOe && masterStateCode == CODE_IDLE;
   endsequence
   property p_reset_idle;
      $fell(reset) |-> !frameOe && !adOe && !irdyOe && masterStateCode == CODE_IDLE;
   endproperty
   property p_pair;
      lowHalfTaken_n == highHalfTaken_n;
   endproperty
   property p_take_in_burst;
      !lowHalfTaken_n |-> frameOe;
   endproperty
   property p_frame_held;
      inXfer && remainingPhaseCount > 1 |-> frameOe && !frameOut_n;
   endproperty
   property p_last_phase;
      frameOe && frameOut_n |-> req64Out_n && lowHalfTaken_n && remainingPhaseCount == 1;
   endproperty
   property p_count_step;
      inXfer && $past(inXfer) && $changed(remainingPhaseCount) |->
         remainingPhaseCount == $past(remainingPhaseCount) - 1'b1 && !$past(irdyOut_n);
   endproperty
   property p_wide_irdy;
      inXfer |-> !wideTransferFlag_n && irdyOe && (!irdyOut_n || $past(irdyOut_n));
   endproperty
   property p_end;
      $rose(masterStateCode == CODE_TERMINATE) |-> s_ended ##1 s_idle;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
   a_pair: assert property (p_pair) else $error("taken strobes differ");
   a_take_in_burst: assert property (p_take_in_burst) else $error("take outside burst");
   a_frame_held: assert property (p_frame_held) else $error("frame dropped early");
   a_last_phase: assert property (p_last_phase) else $error("bad final phase");
   a_count_step: assert property (p_count_step) else $error("bad count step");
   a_wide_irdy: assert property (p_wide_irdy) else $error("wide or irdy missing");
   a_end: assert property (p_end) else $error("bad termination");
endmodule : burst_write_chk

// File: verif/burst_partner.sv
// Model of the local master and the PCI target.
`timescale 1ns/1ns
module burst_partner
   import burst_write_pkg::*;
(
   // Clock, reset and setup.
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic slow,
   input wire logic [3:0] burstLength,
   // Sequencer outputs.
   input wire logic lowHalfTaken_n,
   input wire logic highHalfTaken_n,
   input wire logic irdyOe,
   // Answers.
   output logic localSourceReady_n,
   output logic [DATA_WIDTH-1:0] localData,
   output logic [BE_WIDTH-1:0] localByteEnables,
   output logic devsel_n,
   output logic trdy_n
);
   logic [4:0] idx_r;
   logic [3:0] last_r;
   logic [7:0] tgtCnt_r;
   logic [3:0] nib;
   // Word steps one clock after a take, else it is held.
   always @(posedge clk) begin
      if (reset || load) begin
         idx_r <= 5'h01;
         last_r <= reset ? 4'h0 : burstLength;
      end else if (!lowHalfTaken_n && !highHalfTaken_n) begin
         idx_r <= idx_r + 5'h01;
      end
      tgtCnt_r <= irdyOe ? tgtCnt_r + 8'h01 : 8'h00;
   end
   // Ready until the final word has been taken; words past the end are inverted.
   assign localSourceReady_n = ({1'b0, last_r} < idx_r);
   assign nib = (idx_r > {1'b0, last_r}) ? ~last_r : idx_r[3:0];
   assign localData = {16{nib}};
   assign localByteEnables = {2{nib}};
   // Target claims after a delay and stalls now and then when slow.
   assign devsel_n = !(irdyOe && tgtCnt_r >= (slow ? 8'h04 : 8'h01));
   assign trdy_n = devsel_n || (slow && tgtCnt_r[2:0] == 3'h6);
endmodule : burst_partner

// File: verif/pci_master_burst_write64_tb_top.sv
// Bench for the 64-bit burst write sequencer.
`timescale 1ns/1ns
module pci_master_burst_write64_tb_top
   import burst_write_pkg::*;
;
   logic clk, reset, start, load, slow, haveLast, sawWide, sawEnd, frameOut_n, frameOe, req64Out_n, req64Oe;
   logic localSourceReady_n, devsel_n, trdy_n, lowHalfTaken_n, highHalfTaken_n, wideTransferFlag_n;
   logic irdyOut_n, irdyOe, adOe;
   logic [3:0] burstLength, remainingPhaseCount, masterStateCode, prevCnt;
   logic [1:0] endCause;
   logic [63:0] localData, adOut;
   logic [7:0] localByteEnables, cbenOut;
   logic [71:0] lastBus;
   logic [71:0] words[$];
   int fails, checks, cycles, nDec;
   // Design and far-side model.
   pci_master_burst_write64 dut_u (.clk, .reset, .start, .burstLength, .localSourceReady_n, .localData,
      .localByteEnables, .lowHalfTaken_n, .highHalfTaken_n, .wideTransferFlag_n, .remainingPhaseCount,
      .masterStateCode, .endCause, .devsel_n, .trdy_n, .frameOut_n, .frameOe, .req64Out_n, .req64Oe,
      .irdyOut_n, .irdyOe, .adOut, .cbenOut, .adOe);
   burst_partner partner_u (.clk, .reset, .load, .slow, .burstLength, .lowHalfTaken_n, .highHalfTaken_n,
      .irdyOe, .localSourceReady_n, .localData, .localByteEnables, .devsel_n, .trdy_n);
   // Clock source.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Logs bus words and count steps, and cuts a hang short.
   always @(posedge clk) begin
      if (adOe && masterStateCode === CODE_TRANSFER && (!haveLast || {adOut, cbenOut} !== lastBus)) begin
         words.push_back({adOut, cbenOut});
         lastBus = {adOut, cbenOut};
         haveLast = 1'b1;
      end
      if (wideTransferFlag_n === 1'b0) sawWide = 1'b1;
      if (endCause === CAUSE_NORMAL) sawEnd = 1'b1;
      if (prevCnt != 4'h0 && remainingPhaseCount === prevCnt - 4'h1) nDec++;
      prevCnt = remainingPhaseCount;
      cycles++;
      if (cycles == 3000) begin
         fails++;
         wrap_up();
      end
   end
   // Compares and counts.
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: %0h vs %0h", $time, seen, exp);
      end
   endtask : check
   // Prints the verdict and ends the run.
   task automatic wrap_up();
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   // Sets up the model and gives one start pulse.
   task automatic launch(input logic [3:0] len, input logic sl);
      burstLength = len;
      slow = sl;
      load = 1'b1;
      @(posedge clk);
      #1 load = 1'b0;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      burstLength = 4'h7;
   endtask : launch
   // One burst, with an optional start while busy, judged on both sides.
   task automatic run_burst(input logic [3:0] len, input logic sl, input logic poke);
      int i;
      words.delete();
      haveLast = 1'b0;
      sawWide = 1'b0;
      sawEnd = 1'b0;
      nDec = 0;
      launch(len, sl);
      repeat (3) @(posedge clk);
      #1 start = poke;
      @(posedge clk);
      #1 start = 1'b0;
      i = 0;
      while (masterStateCode !== CODE_IDLE && i < 300) begin
         @(posedge clk);
         #1 i++;
      end
      check(words.size(), len);
      for (i = 0; i < len; i++) check(words[i], {18{4'(i + 1)}});
      check(nDec, len);
      check(sawWide, 1'b1);
      check(sawEnd, 1'b1);
   endtask : run_burst
   // Shortest burst, prompt target.
   task automatic scn_short();
      run_burst(4'h2, 1'b0, 1'b0);
   endtask : scn_short
   // Longest count with a stalling target.
   task automatic scn_long_slow();
      run_burst(4'hF, 1'b1, 1'b0);
   endtask : scn_long_slow
   // A start while busy must be ignored.
   task automatic scn_busy_start();
      run_burst(4'h3, 1'b0, 1'b1);
   endtask : scn_busy_start
   // Reset in mid-burst returns to idle, then a burst runs again.
   task automatic scn_mid_reset();
      launch(4'h4, 1'b0);
      repeat (5) @(posedge clk);
      #1 reset = 1'b1;
      @(posedge clk);
      #1 reset = 1'b0;
      check({frameOe, adOe, irdyOe, lowHalfTaken_n, remainingPhaseCount, masterStateCode}, 12'h100);
      run_burst(4'h3, 1'b0, 1'b0);
   endtask : scn_mid_reset
   // Main sequence.
   initial begin
      reset = 1'b1;
      start = 1'b0;
      load = 1'b0;
      slow = 1'b0;
      burstLength = 4'h2;
      fails = 0;
      checks = 0;
      cycles = 0;
      prevCnt = 4'h0;
      haveLast = 1'b0;
      repeat (10) @(posedge clk);
      #1 reset = 1'b0;
      scn_short();
      scn_long_slow();
      scn_busy_start();
      scn_mid_reset();
      wrap_up();
   end
endmodule : pci_master_burst_write64_tb_top
bind pci_master_burst_write64 burst_write_chk #(.CW(CW)) chk_u (.clk, .reset, .lowHalfTaken_n, .highHalfTaken_n,
   .wideTransferFlag_n, .remainingPhaseCount, .masterStateCode, .endCause, .frameOut_n, .frameOe, .req64Out_n,
   .req64Oe, .irdyOut_n, .irdyOe, .adOe);
